/* design/pcdb_map.vh */
// Functional notes
// - program store is 4K words of 12 bits, sequential binary counter
// - reset loads the program counter with 0FFFh
// - counter increments per instruction and wraps from maximum to zero
// - 512-word pages; sequential counting crosses page edges freely
// - low counter byte readable at 02h; bit 8 hidden; top from page select
// - jumps and calls take upper target bits from page-select bits
// - page instruction loads page-select bits from its operand
// - eight 12-bit stack entries; call pushes, return pops, contents shift
// - stack separate from data memory, no program read or write path
// - data memory: sixteen banks of sixteen bytes plus a global bank
// - 5-bit field: 00h indirect, 01h-0Fh direct, 10h-1Fh semi-direct
// - indirect mode uses the 8-bit bank pointer at 04h as full address
// - indirect 01h-0Fh reach global bank, higher reach banks 1-F
// - direct mode selects a global register, pointer ignored
// - semi-direct joins pointer high nibble with field low nibble
// - global location 00 is the indirect window, not storage
// - bank instruction writes pointer bits 4-6 only
// - pointer bit 7 selects lower or upper block of eight banks
`ifndef PCDB_MAP_VH
`define PCDB_MAP_VH
`define PCDB_PC_RESET     12'h0FFF
`define PCDB_ADDR_WINDOW  5'h00
`define PCDB_ADDR_PCL     5'h02
`define PCDB_ADDR_STATUS  5'h03
`define PCDB_ADDR_POINTER 5'h04
`define PCDB_PTR_RESET    8'h00
`define PCDB_PAGE_RESET   3'h0
`define PCDB_STACK_DEPTH  8
`define PCDB_PAGE_LSB     9
`define PCDB_BANK_LSB     4
`define PCDB_STAT_PA_LSB  5
`define PCDB_STACK_RESET  12'h000
`define PCDB_RDATA_RESET  8'h00
`define PCDB_GLB_WORDS    16
`define PCDB_BANK_WORDS   256
`endif

/* design/pcdb_core.v */
`timescale 1ns/100ps
`include "pcdb_map.vh"
module pcdb_core (
    input  wire        REF_CLK_I,
    input  wire        RESET_N_I,

    input  wire        STEP_I,
    input  wire        JUMP_I,
    input  wire        CALL_I,
    input  wire        RET_I,
    input  wire [8:0]  TARGET_I,

    input  wire        PAGE_I,
    input  wire [2:0]  PAGE_VAL_I,
    input  wire        BANK_I,
    input  wire [7:0]  BANK_VAL_I,

    input  wire [4:0]  REG_FIELD_I,
    input  wire        DATA_WR_I,
    input  wire [7:0]  DATA_WDATA_I,

    output wire [11:0] PC_O,
    output wire [2:0]  PAGE_SEL_O,
    output wire [7:0]  POINTER_O,
    output wire [1:0]  MODE_O,
    output wire [8:0]  DATA_ADDR_O,
    output reg  [7:0]  DATA_RDATA_O
);

    // operating modes reported on MODE_O
    localparam [1:0] MODE_IND  = 2'h0;
    localparam [1:0] MODE_DIR  = 2'h1;
    localparam [1:0] MODE_SEMI = 2'h2;
    // upper address nibble that marks the global bank
    localparam [3:0] GLB       = 4'h8;
    localparam       DEPTH     = `PCDB_STACK_DEPTH;
    localparam       TOP       = `PCDB_STACK_DEPTH - 1;
    localparam       GLB_LAST  = `PCDB_GLB_WORDS - 1;
    localparam       BANK_LAST = `PCDB_BANK_WORDS - 1;

    // program counter and page select
    reg  [11:0] pc_q;
    reg  [11:0] pc_d;
    reg  [2:0]  page_q;
    reg  [2:0]  page_d;
    wire [2:0]  stat_page;
    wire [11:0] pc_inc;
    wire [11:0] branch_tgt;
    wire [11:0] pcl_tgt;
    wire        branch;

    // subroutine stack
    reg  [11:0] stack_q [0:TOP];
    wire [11:0] top_entry;
    wire        push;
    wire        pop;

    // bank pointer and address decode
    reg  [7:0]  ptr_q;
    reg  [7:0]  ptr_d;
    reg  [1:0]  mode;
    reg  [8:0]  addr;
    wire        fld_window;
    wire        fld_semi;
    wire [3:0]  fld_reg;
    wire [3:0]  ptr_bank;
    wire [3:0]  ptr_reg;

    // data storage and special locations
    reg  [7:0]  glb_q [0:GLB_LAST];
    reg  [7:0]  bank_q [0:BANK_LAST];
    reg  [7:0]  stored;
    reg  [7:0]  rdata_d;
    wire        in_glb;
    wire        hit_window;
    wire        hit_pcl;
    wire        hit_status;
    wire        hit_pointer;
    wire        wr_pcl;
    wire        wr_status;
    wire        wr_pointer;
    wire        wr_store;

    // field and pointer split into bank and register nibbles
    assign fld_window = (REG_FIELD_I == `PCDB_ADDR_WINDOW);
    assign fld_semi   = REG_FIELD_I[4];
    assign fld_reg    = REG_FIELD_I[3:0];
    assign ptr_bank   = ptr_q[7:`PCDB_BANK_LSB];
    assign ptr_reg    = ptr_q[`PCDB_BANK_LSB-1:0];

    // mode decode
    always @* begin
        case ({fld_semi, fld_window})
            2'b01: begin
                mode = MODE_IND;
            end
            2'b00: begin
                mode = MODE_DIR;
            end
            default: begin
                mode = MODE_SEMI;
            end
        endcase
    end

    // data address: bit 8 set means global bank, else {bank, reg}
    always @* begin
        addr = {GLB, 1'b0, fld_reg};
        case (mode)
            MODE_IND: begin
                // bank 0 cannot be reached: its codes land in the globals
                if (ptr_bank == 4'h0) begin
                    addr = {GLB, 1'b0, ptr_reg};
                end else begin
                    addr = {1'b0, ptr_q};
                end
            end
            MODE_SEMI: begin
                // pointer low nibble ignored, globals unreachable
                addr = {1'b0, ptr_bank, fld_reg};
            end
            MODE_DIR: begin
                addr = {GLB, 1'b0, fld_reg};
            end
            default: begin
                addr = {GLB, 1'b0, fld_reg};
            end
        endcase
    end

    // special global locations, shadowed in front of the storage array
    assign in_glb      = addr[8];
    assign hit_window  = (addr == {GLB, `PCDB_ADDR_WINDOW});
    assign hit_pcl     = (addr == {GLB, `PCDB_ADDR_PCL});
    assign hit_status  = (addr == {GLB, `PCDB_ADDR_STATUS});
    assign hit_pointer = (addr == {GLB, `PCDB_ADDR_POINTER});
    assign wr_pcl      = DATA_WR_I && hit_pcl;
    assign wr_status   = DATA_WR_I && hit_status;
    assign wr_pointer  = DATA_WR_I && hit_pointer;
    // the window pointing at itself has no storage behind it
    assign wr_store    = DATA_WR_I && !hit_window;

    // rolls over from 0FFFh to 0, no page effect on counting
    assign pc_inc     = pc_q + 12'h0001;
    assign branch_tgt = {page_q, TARGET_I};
    // bit 8 is not writable, so a write to 02h clears it
    assign pcl_tgt    = {page_q, 1'b0, DATA_WDATA_I};
    assign branch     = JUMP_I || CALL_I;
    // return wins over a call in the same cycle, as in the counter
    assign pop        = RET_I;
    assign push       = CALL_I && !RET_I;
    assign top_entry  = stack_q[0];

    // priority: return, branch, write to 02h, then plain step
    always @* begin
        pc_d = pc_q;
        if (RET_I) begin
            pc_d = top_entry;
        end else if (branch) begin
            pc_d = branch_tgt;
        end else if (wr_pcl) begin
            pc_d = pcl_tgt;
        end else if (STEP_I) begin
            pc_d = pc_inc;
        end
    end

    // counter register
    always @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            pc_q <= `PCDB_PC_RESET;
        end else begin
            pc_q <= pc_d;
        end
    end

    // page select, loaded by the page instruction or a status write
    assign stat_page = DATA_WDATA_I[`PCDB_STAT_PA_LSB+2:`PCDB_STAT_PA_LSB];

    always @* begin
        page_d = page_q;
        if (PAGE_I) begin
            page_d = PAGE_VAL_I;
        end else if (wr_status) begin
            page_d = stat_page;
        end
    end

    // page register
    always @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            page_q <= `PCDB_PAGE_RESET;
        end else begin
            page_q <= page_d;
        end
    end

    // bank instruction leaves bit 7 and the low bits alone
    always @* begin
        ptr_d = ptr_q;
        if (BANK_I) begin
            ptr_d[6:4] = BANK_VAL_I[6:4];
        end else if (wr_pointer) begin
            ptr_d = DATA_WDATA_I;
        end
    end

    // pointer register
    always @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ptr_q <= `PCDB_PTR_RESET;
        end else begin
            ptr_q <= ptr_d;
        end
    end

    // stack is reachable only by call and return, never by data access
    // overflow drops the oldest entry, underflow repeats the last one
    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : g_stk
            wire [11:0] below;
            wire [11:0] above;
            reg  [11:0] entry_d;
            if (g == 0) begin : g_first
                assign below = pc_inc;
            end else begin : g_rest
                assign below = stack_q[g-1];
            end
            if (g == TOP) begin : g_last
                assign above = stack_q[g];
            end else begin : g_mid
                assign above = stack_q[g+1];
            end
            always @* begin
                entry_d = stack_q[g];
                if (push) begin
                    entry_d = below;
                end else if (pop) begin
                    entry_d = above;
                end
            end
            // entry register
            always @(posedge REF_CLK_I or negedge RESET_N_I) begin
                if (!RESET_N_I) begin
                    stack_q[g] <= `PCDB_STACK_RESET;
                end else begin
                    stack_q[g] <= entry_d;
                end
            end
        end
    endgenerate

    // global bank and banked storage; special locations shadow globals
    always @(posedge REF_CLK_I) begin
        if (wr_store && in_glb) begin
            glb_q[addr[3:0]] <= DATA_WDATA_I;
        end
    end

    always @(posedge REF_CLK_I) begin
        if (wr_store && !in_glb) begin
            bank_q[addr[7:0]] <= DATA_WDATA_I;
        end
    end

    always @* begin
        if (in_glb) begin
            stored = glb_q[addr[3:0]];
        end else begin
            stored = bank_q[addr[7:0]];
        end
    end

    // registered read, so data lags the field by one cycle
    always @* begin
        rdata_d = stored;
        if (hit_window) begin
            rdata_d = 8'h00;
        end else if (hit_pcl) begin
            rdata_d = pc_q[7:0];
        end else if (hit_status) begin
            rdata_d = {page_q, 5'h00};
        end else if (hit_pointer) begin
            rdata_d = ptr_q;
        end
    end

    // read data register
    always @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            DATA_RDATA_O <= `PCDB_RDATA_RESET;
        end else begin
            DATA_RDATA_O <= rdata_d;
        end
    end

    // outputs straight from the flops and the decoder
    assign PC_O        = pc_q;
    assign PAGE_SEL_O  = page_q;
    assign POINTER_O   = ptr_q;
    assign MODE_O      = mode;
    assign DATA_ADDR_O = addr;
endmodule

/* bench/pcdb_chk.sv */
`timescale 1ns/100ps
module pcdb_chk (input wire REF_CLK_I, RESET_N_I, STEP_I, JUMP_I, CALL_I,
    RET_I, PAGE_I, BANK_I, DATA_WR_I, input wire [8:0] TARGET_I, DATA_ADDR_O,
    input wire [2:0] PAGE_VAL_I, PAGE_SEL_O, input wire [7:0] BANK_VAL_I,
    POINTER_O, input wire [4:0] REG_FIELD_I, input wire [11:0] PC_O,
    input wire [1:0] MODE_O);
    wire quiet = ~|{JUMP_I, CALL_I, RET_I, DATA_WR_I};
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    chk_pc_step: assert property (STEP_I && quiet
        |=> PC_O == $past(PC_O) + 12'h001) else $error("pc step");
    chk_branch_page: assert property (
        (JUMP_I || CALL_I) && !RET_I
        |=> PC_O == {$past(PAGE_SEL_O), $past(TARGET_I)}) else $error("jump");
    chk_call_ret: assert property (CALL_I && !RET_I ##1 RET_I
        |=> PC_O == $past(PC_O, 2) + 12'h001) else $error("return");
    chk_page_load: assert property (PAGE_I && !DATA_WR_I
        |=> PAGE_SEL_O == $past(PAGE_VAL_I)) else $error("page");
    chk_bank_bits: assert property (BANK_I && !DATA_WR_I
        |=> POINTER_O == (($past(POINTER_O) & 8'h8F)
        | ($past(BANK_VAL_I) & 8'h70))) else $error("bank");
    chk_mode_dec: assert property (
        MODE_O == (REG_FIELD_I[4] ? 2'h2 : {1'b0, |REG_FIELD_I}))
        else $error("mode");
    chk_semi_addr: assert property (REG_FIELD_I[4]
        |-> DATA_ADDR_O == {1'b0, POINTER_O[7:4], REG_FIELD_I[3:0]})
        else $error("semi");
    chk_ind_addr: assert property (REG_FIELD_I == 5'h00
        |-> DATA_ADDR_O == (|POINTER_O[7:4] ? {1'b0, POINTER_O}
        : {5'h10, POINTER_O[3:0]})) else $error("indirect");
    cov_call: cover property (CALL_I ##1 RET_I);
    cov_wrap: cover property (PC_O == 12'hFFF ##1 PC_O == 12'h000);
    cov_ind: cover property (REG_FIELD_I == 5'h00 && DATA_WR_I);
endmodule
bind pcdb_core pcdb_chk chk_u (.*);

/* bench/tb_pcdb_core.sv */
`timescale 1ns/100ps
module tb_pcdb_core;
    localparam ST = 7'h01, JP = 7'h02, CL = 7'h04, RT = 7'h08, BK = 7'h20;
    localparam PG = 7'h10, WR = 7'h40;
    reg         clk = 0, rst_n = 0;
    reg  [6:0]  s = 0;
    reg  [8:0]  tgt = 0;
    reg  [7:0]  bv = 0, wd = 0;
    reg  [4:0]  fld = 0;
    wire [11:0] pc;
    wire [8:0]  da;
    wire [7:0]  ptr, rd;
    wire [2:0]  ps;
    wire [1:0]  md;
    integer     fail_count = 0, n_tests = 0;
    pcdb_core dut_u (.REF_CLK_I(clk), .RESET_N_I(rst_n), .STEP_I(s[0]),
        .JUMP_I(s[1]), .CALL_I(s[2]), .RET_I(s[3]), .TARGET_I(tgt),
        .PAGE_I(s[4]), .PAGE_VAL_I(bv[2:0]), .BANK_I(s[5]), .BANK_VAL_I(bv),
        .REG_FIELD_I(fld), .DATA_WR_I(s[6]), .DATA_WDATA_I(wd), .PC_O(pc),
        .PAGE_SEL_O(ps), .POINTER_O(ptr), .MODE_O(md), .DATA_ADDR_O(da),
        .DATA_RDATA_O(rd));
    initial forever #5 clk = ~clk;
    // strobe stays up until the next op, so the strobes change only once per step
    task op(input [6:0] v);
        s = v;
        @(posedge clk) #1;
    endtask
    task cmp(input string n, input [11:0] e, g);
        n_tests = n_tests + 1;
        fail_count = fail_count + (g !== e);
        if (g !== e) $display("ERROR %s expected %h seen %h", n, e, g);
    endtask
    task conclude;
        $display("compares %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task t_pc;
        cmp("pc", 12'hFFF, pc);
        op(ST); cmp("pc", 12'h000, pc);
        tgt = 9'h1FF; op(JP); op(ST); cmp("pc", 12'h200, pc);
        bv = 8'h05; op(PG); tgt = 9'h012; op(CL); cmp("pc", 12'hA12, pc);
        op(RT); cmp("pc", 12'h201, pc);
        fld = 5'h02; wd = 8'h34; op(WR); cmp("pc", 12'hA34, pc);
    endtask
    task t_data;
        fld = 5'h04; wd = 8'hF5; op(WR); bv = 8'h20; op(BK);
        cmp("ptr", 8'hA5, ptr);
        fld = 5'h00; wd = 8'h5A; op(WR); cmp("ind", 9'h0A5, da);
        op(0); cmp("rd", 8'h5A, rd);
        fld = 5'h1F; #1 cmp("semi", 9'h0AF, da);
        fld = 5'h0F; #1 cmp("dir", 9'h10F, da);
        cmp("mode", 2'h1, md);
        fld = 5'h04; wd = 8'h05; op(WR); fld = 5'h00;
        #1 cmp("ind", 9'h105, da);
        fld = 5'h04; wd = 8'h00; op(WR); fld = 5'h00; wd = 8'h77; op(WR);
        op(0); cmp("win", 8'h00, rd);
        fld = 5'h02; op(0); cmp("pcl", 8'h34, rd);
        fld = 5'h03; wd = 8'h60; op(WR); cmp("page", 3'h3, ps);
        op(0); cmp("stat", 8'h60, rd);
    endtask
    initial begin
        repeat (200) @(posedge clk);
        fail_count = fail_count + 1;
        conclude;
    end
    initial begin
        repeat (10) @(posedge clk);
        #1 rst_n = 1;
        t_pc;
        t_data;
        conclude;
    end
endmodule
